// file: cfg_parser_pkg.sv
// constants and types for the configuration packet parser
// assumes a 100 MHz clock, an Avalon-MM host and a 16-bit word source
//
// Notes on behaviour
// - Configuration content arrives and is consumed as 16-bit words, and one value may span words.
// - The two-bit operation field decodes as 00 no-operation, 01 register read, 10 register write.
// - A short header has 001 in bits 15:13, operation in 12:11, address in 10:5, count in 4:0.
// - After a short header exactly its five-bit count of data words follow as payload; after a no-operation short header the parser takes no payload.
// - A long header has 010 in bits 15:13 and zeros in 4:0, and may only follow a short packet.
// - After a long header the 32-bit count comes as two words, high half first, top four bits zero.
// - A long payload holds exactly the 32-bit count of words, then header parsing resumes; after a no-operation long header the parser takes no payload.
// - Commands take effect only through register accesses, at the moment the command register is written.
// - Configuration memory is acted on in whole frames only, typically 65 words long.
// - Frames fall into category 0 core logic, 1 block memory and 2 input/output block settings.
// - Frame data is accepted only once the command register holds the write-configuration command.

package cfg_parser_pkg;

   // ==========================================================
   // header layout
   localparam int HDR_TYPE_HI = 15;
   localparam int HDR_TYPE_LO = 13;
   localparam int HDR_OP_HI = 12;
   localparam int HDR_OP_LO = 11;
   localparam int HDR_ADDR_HI = 10;
   localparam int HDR_ADDR_LO = 5;
   localparam int HDR_COUNT_HI = 4;
   localparam int HDR_COUNT_LO = 0;
   localparam int COUNT_TOP_HI = 15;
   localparam int COUNT_TOP_LO = 12;
   localparam logic [2:0] TYPE_SHORT = 3'h1;
   localparam logic [2:0] TYPE_LONG = 3'h2;
   localparam logic [1:0] OP_NOP = 2'h0;
   localparam logic [1:0] OP_READ = 2'h1;
   localparam logic [1:0] OP_WRITE = 2'h2;

   // ==========================================================
   // configuration register addresses and command codes
   localparam logic [5:0] ADDR_FAR_MAJ = 6'h01;
   localparam logic [5:0] ADDR_FRAME_DATA_IN = 6'h03;
   localparam logic [5:0] ADDR_CMD = 6'h05;
   localparam logic [5:0] ADDR_ID_CHECK = 6'h0E;
   localparam int CMD_HI = 4;
   localparam logic [4:0] CMD_NULL = 5'h00;
   localparam logic [4:0] WRITE_CONFIG_COMMAND = 5'h01;
   localparam int FAR_BLK_HI = 15;
   localparam int FAR_BLK_LO = 12;
   localparam logic [15:0] FRAME_LEN_RESET = 16'h0041;
   localparam logic [31:0] DEVICE_ID_DEFAULT = 32'h0000A5A5; // arbitrary value

   // ==========================================================
   // host register map, byte offsets
   localparam logic [4:0] OFS_CONTROL = 5'h00;
   localparam logic [4:0] OFS_STATUS = 5'h04;
   localparam logic [4:0] OFS_FRAMES = 5'h08;
   localparam logic [4:0] OFS_FRAME_LEN = 5'h0C;
   localparam logic [4:0] OFS_REMAIN = 5'h10;
   localparam logic [4:0] OFS_DEVICE_ID = 5'h14;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_RESYNC_BIT = 1;
   localparam int CTRL_CLEAR_BIT = 2;
   localparam logic CTRL_ENABLE_RESET = 1'b1;
   localparam int ERR_ORPHAN_LONG = 0;
   localparam int ERR_BAD_TYPE = 1;
   localparam int ERR_PARTIAL_FRAME = 2;
   localparam int ERR_FRAME_DATA_IN_REG_DROP = 3;
   localparam int ERR_COUNT_TOP = 4;
   localparam int ERR_W = 5;

   // ==========================================================
   // output buffer shape
   localparam int ENTRY_W = 24;
   localparam int BUF_DEPTH = 2;

   // ==========================================================
   // types
   typedef enum logic [1:0] {st_header, st_count_hi, st_count_lo, st_payload} parse_state_t;
   typedef enum logic [1:0] {
      logic_tile_frames,
      block_memory_frames,
      io_block_frames,
      unknown_frames
   } frame_cat_t;

   // block field of the frame address to frame category
   function automatic frame_cat_t frame_category(input logic [3:0] blk);
      frame_category = (blk == 4'h0) ? logic_tile_frames :
                       (blk == 4'h1) ? block_memory_frames :
                       (blk == 4'h2) ? io_block_frames : unknown_frames;
   endfunction

endpackage

// file: entry_buffer.sv
// small first-in first-out buffer with valid and ready on both sides
// assumes one clock and an active-low asynchronous reset

module entry_buffer #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // fill side
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // drain side
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;

   // ==========================================================
   // handshake decode
   wire logic push = in_valid_in && in_ready_out;
   wire logic pop = out_valid_out && out_ready_in;
   wire logic [PTR_W-1:0] next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
   wire logic [PTR_W-1:0] next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;

   assign in_ready_out = (count != FULL);
   assign out_valid_out = (count != '0);
   assign out_data_out = mem[rd_ptr];

   // storage, data only so no reset
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= next_wr_ptr;
         if (pop) rd_ptr <= next_rd_ptr;
         if (push && !pop) count <= count + 1'b1;
         else if (pop && !push) count <= count - 1'b1;
      end
   end

endmodule

// file: config_packet_parser.sv
// configuration packet parser: headers, long counts, register writes, frames
// assumes a word source with valid/ready, an Avalon-MM host for status and
// a downstream register file that takes access entries with valid/ready

module config_packet_parser #(
   parameter logic [31:0] DEVICE_ID = cfg_parser_pkg::DEVICE_ID_DEFAULT // arbitrary value
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // bitstream word source
   input wire logic word_valid_in,
   input wire logic [15:0] word_in,
   output logic word_ready_out,
   // register access entries to the configuration registers
   output logic acc_valid_out,
   output logic acc_write_out,
   output logic [5:0] acc_addr_out,
   output logic [15:0] acc_data_out,
   output logic acc_frame_last_out,
   input wire logic acc_ready_in,
   // frame category of the addressed block
   output logic [1:0] frame_cat_out,
   // avalon-mm slave
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);

   cfg_parser_pkg::parse_state_t state;
   cfg_parser_pkg::parse_state_t next_state;
   logic [31:0] remain;
   logic [31:0] next_remain;
   logic [1:0] pkt_op;
   logic [5:0] pkt_addr;
   logic prev_short;
   logic [4:0] cmd_reg;
   logic [3:0] far_blk;
   logic id_idx;
   logic [15:0] id_hi;
   logic id_matched;
   logic [15:0] frame_word_cnt;
   logic [31:0] frames_done;
   logic [cfg_parser_pkg::ERR_W-1:0] err_flags;
   logic enable;
   logic [15:0] frame_len;
   logic resp;
   logic buf_in_ready;
   logic [cfg_parser_pkg::ENTRY_W-1:0] buf_out;

   // ==========================================================
   // header field decode
   wire logic [2:0] hdr_type = word_in[cfg_parser_pkg::HDR_TYPE_HI:cfg_parser_pkg::HDR_TYPE_LO];
   wire logic [1:0] hdr_op = word_in[cfg_parser_pkg::HDR_OP_HI:cfg_parser_pkg::HDR_OP_LO];
   wire logic [5:0] hdr_addr = word_in[cfg_parser_pkg::HDR_ADDR_HI:cfg_parser_pkg::HDR_ADDR_LO];
   wire logic [4:0] hdr_count = word_in[cfg_parser_pkg::HDR_COUNT_HI:cfg_parser_pkg::HDR_COUNT_LO];
   wire logic is_short = (hdr_type == cfg_parser_pkg::TYPE_SHORT);
   wire logic is_long = (hdr_type == cfg_parser_pkg::TYPE_LONG) && (hdr_count == 5'h00);

   // ==========================================================
   // word handshake; reads generate entries without taking words
   wire logic in_read = (state == cfg_parser_pkg::st_payload) && (pkt_op == cfg_parser_pkg::OP_READ);
   wire logic resync = avs_write_in && resp && (avs_address_in == cfg_parser_pkg::OFS_CONTROL) &&
                       avs_byteenable_in[0] && avs_writedata_in[cfg_parser_pkg::CTRL_RESYNC_BIT];
   assign word_ready_out = enable && buf_in_ready && !in_read && !resync;
   wire logic take = word_valid_in && word_ready_out;
   wire logic read_step = in_read && enable && buf_in_ready && !resync;
   wire logic hdr_take = take && (state == cfg_parser_pkg::st_header);
   wire logic pay_take = take && (state == cfg_parser_pkg::st_payload);

   // ==========================================================
   // header classes
   // operation decode
   wire logic op_live = (hdr_op == cfg_parser_pkg::OP_READ) || (hdr_op == cfg_parser_pkg::OP_WRITE);
   wire logic short_go = hdr_take && is_short && op_live && (hdr_count != 5'h00);
   wire logic orphan = hdr_take && is_long && !prev_short;
   wire logic long_go = hdr_take && is_long && prev_short;
   wire logic bad_type = hdr_take && !is_short && !is_long && (hdr_type != cfg_parser_pkg::TYPE_LONG);
   wire logic bad_long = hdr_take && (hdr_type == cfg_parser_pkg::TYPE_LONG) && !is_long;

   // ==========================================================
   // payload steering
   wire logic pay_write = pay_take && (pkt_op == cfg_parser_pkg::OP_WRITE);
   wire logic is_frame_data_in_reg = (pkt_addr == cfg_parser_pkg::ADDR_FRAME_DATA_IN);
   wire logic frame_data_in_reg_ok = (cmd_reg == cfg_parser_pkg::WRITE_CONFIG_COMMAND);
   wire logic drop_frame_data_in_reg = pay_write && is_frame_data_in_reg && !frame_data_in_reg_ok;
   wire logic frame_word = pay_write && is_frame_data_in_reg && frame_data_in_reg_ok;
   wire logic frame_end = frame_word && (frame_word_cnt == frame_len - 16'h0001);
   wire logic last_word = (pay_take || read_step) && (remain == 32'h00000001);
   wire logic partial = last_word && frame_word && !frame_end;
   wire logic push = read_step || (pay_write && !drop_frame_data_in_reg);
   wire logic [15:0] push_data = in_read ? 16'h0000 : word_in;
   wire logic [cfg_parser_pkg::ENTRY_W-1:0] entry = {!in_read, pkt_addr, push_data, frame_end};
   wire logic [31:0] count_full = {remain[31:16], word_in};
   wire logic count_top_bad = take && (state == cfg_parser_pkg::st_count_hi) &&
                (word_in[cfg_parser_pkg::COUNT_TOP_HI:cfg_parser_pkg::COUNT_TOP_LO] != 4'h0);

   // ==========================================================
   // next state of the packet walk
   always_comb begin
      next_state = state;
      next_remain = remain;
      unique case (state)
         cfg_parser_pkg::st_header: begin
            if (short_go) begin
               next_state = cfg_parser_pkg::st_payload;
               next_remain = {27'h0000000, hdr_count};
            end else if (long_go) begin
               next_state = cfg_parser_pkg::st_count_hi;
            end
         end
         cfg_parser_pkg::st_count_hi: begin
            if (take) begin
               next_state = cfg_parser_pkg::st_count_lo;
               next_remain = {word_in, 16'h0000};
            end
         end
         cfg_parser_pkg::st_count_lo: begin
            if (take) begin
               next_remain = count_full;
               next_state = (count_full == 32'h00000000 || pkt_op == cfg_parser_pkg::OP_NOP) ?
                            cfg_parser_pkg::st_header : cfg_parser_pkg::st_payload;
            end
         end
         cfg_parser_pkg::st_payload: begin
            if (take || read_step) begin
               next_remain = remain - 32'h00000001;
               if (last_word) next_state = cfg_parser_pkg::st_header;
            end
         end
      endcase
      if (resync) begin
         next_state = cfg_parser_pkg::st_header;
         next_remain = 32'h00000000;
      end
   end

   // packet state registers
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= cfg_parser_pkg::st_header;
         remain <= 32'h00000000;
         pkt_op <= cfg_parser_pkg::OP_NOP;
         pkt_addr <= 6'h00;
         prev_short <= 1'b0;
      end else begin
         state <= next_state;
         remain <= next_remain;
         if (hdr_take && (is_short || long_go)) begin
            pkt_op <= hdr_op;
            pkt_addr <= hdr_addr;
         end
         if (hdr_take) prev_short <= is_short;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cmd_reg <= cfg_parser_pkg::CMD_NULL;
         far_blk <= 4'h0;
      end else if (pay_write) begin
         if (pkt_addr == cfg_parser_pkg::ADDR_CMD) cmd_reg <= word_in[cfg_parser_pkg::CMD_HI:0];
         if (pkt_addr == cfg_parser_pkg::ADDR_FAR_MAJ) begin
            far_blk <= word_in[cfg_parser_pkg::FAR_BLK_HI:cfg_parser_pkg::FAR_BLK_LO];
         end
      end
   end

   // identifier check, two words high half first
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         id_idx <= 1'b0;
         id_hi <= 16'h0000;
         id_matched <= 1'b0;
      end else if (hdr_take) begin
         id_idx <= 1'b0;
      end else if (pay_write && pkt_addr == cfg_parser_pkg::ADDR_ID_CHECK) begin
         id_idx <= !id_idx;
         if (!id_idx) id_hi <= word_in;
         else id_matched <= ({id_hi, word_in} == DEVICE_ID);
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         frame_word_cnt <= 16'h0000;
         frames_done <= 32'h00000000;
      end else if (frame_end || partial) begin
         frame_word_cnt <= 16'h0000;
         if (frame_end) frames_done <= frames_done + 32'h00000001;
      end else if (frame_word) begin
         frame_word_cnt <= frame_word_cnt + 16'h0001;
      end
   end

   // frame category from the block field
   assign frame_cat_out = cfg_parser_pkg::frame_category(far_blk);

   // ==========================================================
   // output buffer toward the configuration registers
   entry_buffer #(
      .WIDTH(cfg_parser_pkg::ENTRY_W),
      .DEPTH(cfg_parser_pkg::BUF_DEPTH)
   ) u_buffer (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .in_valid_in(push),
      .in_data_in(entry),
      .in_ready_out(buf_in_ready),
      .out_valid_out(acc_valid_out),
      .out_data_out(buf_out),
      .out_ready_in(acc_ready_in)
   );

   assign acc_write_out = buf_out[23];
   assign acc_addr_out = buf_out[22:17];
   assign acc_data_out = buf_out[16:1];
   assign acc_frame_last_out = buf_out[0];

   // ==========================================================
   // avalon slave: one wait state per access
   wire logic access = avs_read_in || avs_write_in;
   wire logic do_write = avs_write_in && resp;
   wire logic wr_ctrl = do_write && (avs_address_in == cfg_parser_pkg::OFS_CONTROL);
   wire logic wr_len = do_write && (avs_address_in == cfg_parser_pkg::OFS_FRAME_LEN);
   wire logic err_clear = wr_ctrl && avs_byteenable_in[0] &&
                          avs_writedata_in[cfg_parser_pkg::CTRL_CLEAR_BIT];
   wire logic [cfg_parser_pkg::ERR_W-1:0] err_set = {count_top_bad, drop_frame_data_in_reg, partial,
                                                     bad_type || bad_long, orphan};
   wire logic [31:0] status_word = {19'h00000, err_flags, 1'b0, frame_cat_out, id_matched,
                                    frame_data_in_reg_ok, prev_short, state};
   wire logic [31:0] read_mux =
      (avs_address_in == cfg_parser_pkg::OFS_CONTROL) ? {31'h00000000, enable} :
      (avs_address_in == cfg_parser_pkg::OFS_STATUS) ? status_word :
      (avs_address_in == cfg_parser_pkg::OFS_FRAMES) ? frames_done :
      (avs_address_in == cfg_parser_pkg::OFS_FRAME_LEN) ? {16'h0000, frame_len} :
      (avs_address_in == cfg_parser_pkg::OFS_REMAIN) ? remain :
      (avs_address_in == cfg_parser_pkg::OFS_DEVICE_ID) ? DEVICE_ID : 32'h00000000;

   assign avs_waitrequest_out = access && !resp;

   // bus response and read capture
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         resp <= 1'b0;
         avs_readdata_out <= 32'h00000000;
      end else begin
         resp <= access && !resp;
         if (avs_read_in && !resp) avs_readdata_out <= read_mux;
      end
   end

   // software registers; a flag set wins over its clear
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         enable <= cfg_parser_pkg::CTRL_ENABLE_RESET;
         frame_len <= cfg_parser_pkg::FRAME_LEN_RESET;
         err_flags <= '0;
      end else begin
         if (wr_ctrl && avs_byteenable_in[0]) begin
            enable <= avs_writedata_in[cfg_parser_pkg::CTRL_ENABLE_BIT];
         end
         if (wr_len && avs_byteenable_in[0]) frame_len[7:0] <= avs_writedata_in[7:0];
         if (wr_len && avs_byteenable_in[1]) frame_len[15:8] <= avs_writedata_in[15:8];
         err_flags <= (err_flags & ~{cfg_parser_pkg::ERR_W{err_clear}}) | err_set;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   chk_short_decode: assert property (
      short_go && !resync |=> state == cfg_parser_pkg::st_payload && pkt_addr == $past(hdr_addr)
         && remain == {27'h0000000, $past(hdr_count)})
      else $error("short header fields not taken");
   chk_op_decode: assert property (
      short_go && hdr_op == cfg_parser_pkg::OP_READ |=> in_read)
      else $error("read operation not decoded");
   chk_empty_packet: assert property (
      hdr_take && is_short && (!op_live || hdr_count == 5'h00) |=> state == cfg_parser_pkg::st_header)
      else $error("empty packet consumed payload");
   chk_orphan_long: assert property (
      orphan |=> state == cfg_parser_pkg::st_header && err_flags[cfg_parser_pkg::ERR_ORPHAN_LONG])
      else $error("orphan long header not ignored");
   chk_long_follows: assert property (
      state == cfg_parser_pkg::st_count_hi && $past(state) != cfg_parser_pkg::st_count_hi
         |-> $past(prev_short))
      else $error("long header accepted without short packet");
   chk_count_order: assert property (
      take && state == cfg_parser_pkg::st_count_hi && !resync ##1 take && !resync
         |=> remain == {$past(word_in, 2), $past(word_in)} || state == cfg_parser_pkg::st_header)
      else $error("long count halves out of order");
   chk_payload_end: assert property (
      last_word && !resync |=> state == cfg_parser_pkg::st_header)
      else $error("payload did not end on its count");
   chk_frame_data_in_reg_gate: assert property (
      push && entry[23] && is_frame_data_in_reg |-> cmd_reg == cfg_parser_pkg::WRITE_CONFIG_COMMAND)
      else $error("frame data passed without write command");
   chk_cmd_capture: assert property (
      pay_write && pkt_addr == cfg_parser_pkg::ADDR_CMD |=> cmd_reg == $past(word_in[4:0]))
      else $error("command register not updated on write");
   chk_frame_wrap: assert property (
      frame_end |=> frame_word_cnt == 16'h0000 && frames_done == $past(frames_done) + 32'h1)
      else $error("frame not closed at its length");
   chk_word_stall: assert property (
      !buf_in_ready |-> !word_ready_out && !push)
      else $error("word taken while buffer full");

   cov_short_write: cover property (pay_write ##1 acc_valid_out);
   cov_long_packet: cover property (long_go ##1 take ##1 take ##[1:20] last_word);
   cov_frame_done: cover property (frame_end);
   cov_buffer_full: cover property (word_valid_in && !buf_in_ready && enable);

endmodule

// file: cfg_word_source.sv
// bitstream word source model for the parser bench
// assumes a word is taken at the rising edge where valid and ready are high
module cfg_word_source (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // word stream
   input wire logic word_ready_in,
   output logic word_valid_out,
   output logic [15:0] word_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] q[$];
   // ==========================================
   // whole words, held until taken
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         word_valid_out <= 1'b0;
         word_out <= 16'hFFFF;
      end else begin
         if (word_valid_out && word_ready_in) void'(q.pop_front());
         word_valid_out <= (q.size() != 0);
         word_out <= (q.size() != 0) ? q[0] : ~word_out; // idle data keeps toggling
      end
   end
endmodule

// file: test_config_packet_parser.sv
// self-checking bench for the configuration packet parser
// assumes the word source model and a stallable access receiver
module test_config_packet_parser;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic acc_ready_in = 1'b1;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic word_valid_in, word_ready_out, acc_valid_out, acc_write_out, acc_frame_last_out;
   logic avs_waitrequest_out;
   logic [4:0] avs_address_in = 5'h00;
   logic [5:0] acc_addr_out;
   logic [1:0] frame_cat_out;
   logic [15:0] word_in, acc_data_out;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rdata;
   logic [22:0] got[$], exp_q[$];
   int fails = 0, checks = 0, lasts = 0;
   always #5 clk_in = ~clk_in;
   cfg_word_source src (.clk_in(clk_in), .resetn_in(resetn_in), .word_ready_in(word_ready_out),
      .word_valid_out(word_valid_in), .word_out(word_in));
   config_packet_parser uut (.clk_in(clk_in), .resetn_in(resetn_in),
      .word_valid_in(word_valid_in), .word_in(word_in), .word_ready_out(word_ready_out),
      .acc_valid_out(acc_valid_out), .acc_write_out(acc_write_out), .acc_addr_out(acc_addr_out),
      .acc_data_out(acc_data_out), .acc_frame_last_out(acc_frame_last_out),
      .acc_ready_in(acc_ready_in), .frame_cat_out(frame_cat_out),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));
   // receiver collects every entry it takes
   always @(posedge clk_in) if (acc_valid_out && acc_ready_in) begin
      got.push_back({acc_write_out, acc_addr_out, acc_data_out});
      lasts += acc_frame_last_out;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_read_in <= !wr;
      avs_write_in <= wr;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 50);
      rdata = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      if (n >= 50) fails++;
      @(posedge clk_in);
   endtask
   task automatic put(input logic [15:0] w);
      src.q.push_back(w);
   endtask
   function automatic void ex(input logic w, input logic [5:0] a, input logic [15:0] d);
      exp_q.push_back({w, a, d});
   endfunction
   // wait for the stream to drain, then compare the entries
   task automatic settle();
      int n;
      n = 0;
      while ((src.q.size() != 0 || got.size() != exp_q.size()) && n < 2000) begin
         @(posedge clk_in);
         n++;
      end
      repeat (3) @(posedge clk_in);
      chk(got.size(), exp_q.size());
      foreach (exp_q[i]) chk(got[i], exp_q[i]);
      got.delete();
      exp_q.delete();
      $display("test ends at %0t", $time);
   endtask
   task automatic end_sim();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      put(16'h5060);
      settle();
      bus(1'b0, 5'h04, 32'h0);
      chk(rdata[8], 1'b1);
      bus(1'b1, 5'h00, 32'h5);
      put(16'h30A1);
      put(16'h0001);
      put(16'h2000);
      ex(1'b1, 6'h05, 16'h0001);
      settle();
      bus(1'b0, 5'h04, 32'h0);
      chk(rdata[3], 1'b1);
      chk(rdata[1:0], 2'h0);
      acc_ready_in <= 1'b0;
      put(16'h30E3);
      for (int i = 0; i < 3; i++) begin
         put(16'hA000 + 16'(i));
         ex(1'b1, 6'h07, 16'hA000 + 16'(i));
      end
      repeat (12) @(posedge clk_in);
      chk(word_ready_out, 1'b0);
      chk(got.size(), 0);
      acc_ready_in <= 1'b1;
      settle();
      put(16'h2902);
      ex(1'b0, 6'h08, 16'h0000);
      ex(1'b0, 6'h08, 16'h0000);
      settle();
      put(16'h3021);
      put(16'h2000);
      ex(1'b1, 6'h01, 16'h2000);
      put(16'h31C2);
      put(cfg_parser_pkg::DEVICE_ID_DEFAULT[31:16]);
      put(cfg_parser_pkg::DEVICE_ID_DEFAULT[15:0]);
      ex(1'b1, 6'h0E, cfg_parser_pkg::DEVICE_ID_DEFAULT[31:16]);
      ex(1'b1, 6'h0E, cfg_parser_pkg::DEVICE_ID_DEFAULT[15:0]);
      put(16'h3060);
      put(16'h5060);
      put(16'h0000);
      put(16'h0082);
      for (int i = 0; i < 130; i++) begin
         put(16'(i));
         ex(1'b1, 6'h03, 16'(i));
      end
      settle();
      chk(frame_cat_out, 2'h2);
      chk(lasts, 2);
      bus(1'b0, 5'h08, 32'h0);
      chk(rdata, 32'h2);
      bus(1'b0, 5'h10, 32'h0);
      chk(rdata, 32'h0);
      bus(1'b0, 5'h0C, 32'h0);
      chk(rdata, 32'h41);
      put(16'h30A1);
      put(16'h0000);
      put(16'h3061);
      put(16'hBEEF);
      ex(1'b1, 6'h05, 16'h0000);
      settle();
      bus(1'b0, 5'h04, 32'h0);
      chk(rdata[4], 1'b1);
      chk(rdata[11], 1'b1);
      chk(rdata[3], 1'b0);
      bus(1'b1, 5'h1C, 32'hFFFFFFFF);
      bus(1'b0, 5'h1C, 32'h0);
      chk(rdata, 32'h0);
      end_sim();
   end
   // watchdog cuts a hang short
   initial begin
      #100000;
      fails++;
      end_sim();
   end
endmodule
